//--- logic/spi_mem_device.sv
// module: serial front end of the non-volatile memory, command decode and status
// Function
// - Operate only while select is low
// - Deselected: ignore input, output floats
// - Capture input bits on rising clock
// - Launch output bits on falling clock
// - Pause freezes exchange, keeps sequence position
// - Clock modes 0 and 3 only
// - Frame starts after select falls, MSB first
// - Write: address, 1-32 bytes; read: unbounded
// - Fast read: address, dummy, then data
// - Write enable/disable single; status read repeats
// - Page erase addressed; chip erases single byte
// - Power down and resume single byte
// - Status eight bits, upper six zero
// - Status bit 0 shows busy
// - Status bit 1 shows write enable latch
// - Latch cleared by power-up, write disable and completed write, erase or power down
// - Write without latch ignored until reselect
// - While busy only status read accepted
// - Continuous read increments and wraps address
`timescale 1ns/10ps
module spi_mem_device #(
    parameter int addr_w = spi_mem_pkg::addr_width
) (
    input  wire logic              clk,
    input  wire logic              rst,
    spi_mem_if.device              link,
    input  wire logic              busy,
    input  wire logic [7:0]        rd_data,
    output logic [addr_w-1:0]      rd_addr,
    output logic                   wr_strobe,
    output logic [addr_w-1:0]      wr_addr,
    output logic [7:0]             wr_data,
    output logic                   write_commit,
    output logic                   page_erase,
    output logic                   chip_erase,
    output logic                   power_down,
    output logic                   standby
);
    typedef struct packed {
        logic [1:0]                 cs_s;
        logic [1:0]                 sck_s;
        logic [1:0]                 serial_in_s;
        logic [1:0]                 hold_s;
        logic                       cs_d;
        logic                       sck_d;
        spi_mem_pkg::dev_phase_type phase;
        logic [2:0]                 bit_cnt;
        logic                       addr_hi_done;
        logic [7:0]                 shift_in;
        logic [7:0]                 shift_out;
        logic [7:0]                 opcode;
        logic [15:0]                addr;
        logic                       data_seen;
        logic                       write_enable_latch;
        logic                       asleep;
        logic                       sout;
        logic                       sout_oe_n;
        logic [addr_w-1:0]          rd_addr;
        logic                       wr_strobe;
        logic [addr_w-1:0]          wr_addr;
        logic [7:0]                 wr_data;
        logic                       write_commit;
        logic                       page_erase;
        logic                       chip_erase;
        logic                       standby;
    } dev_state_type;

    dev_state_type r;
    dev_state_type n;
    logic          sel;
    logic          held;
    logic          sck_rise;
    logic          sck_fall;
    logic [7:0]    in_byte;
    logic [7:0]    device_status;
    logic [7:0]    src;

    // edges seen on the second synchroniser stage only
    assign sel      = !r.cs_s[1];
    assign held     = !r.hold_s[1];
    assign sck_rise = r.sck_s[1] && !r.sck_d;
    assign sck_fall = !r.sck_s[1] && r.sck_d;
    assign in_byte  = {r.shift_in[6:0], r.serial_in_s[1]};

    // status byte rebuilt every time it is loaded for shifting
    always_comb begin
        device_status = spi_mem_pkg::status_reset;
        device_status[spi_mem_pkg::busy_flag_pos] = busy;
        device_status[spi_mem_pkg::latch_pos]     = r.write_enable_latch;
        src = (r.opcode == spi_mem_pkg::status_read_cmd) ? device_status : rd_data;
    end

    // frame decoder
    always_comb begin
        n = r;
        n.cs_s         = {r.cs_s[0], link.select_n};
        n.sck_s        = {r.sck_s[0], link.sck};
        n.serial_in_s  = {r.serial_in_s[0], link.serial_in};
        n.hold_s       = {r.hold_s[0], link.pause_n};
        n.cs_d         = r.cs_s[1];
        n.sck_d        = r.sck_s[1];
        n.wr_strobe    = 1'h0;
        n.write_commit = 1'h0;
        n.page_erase   = 1'h0;
        n.chip_erase   = 1'h0;
        n.standby      = !sel;
        if (r.cs_d && sel) begin
            // new frame; mode 0 or 3 alike, first rise is bit 7
            n.phase        = spi_mem_pkg::ph_opcode;
            n.bit_cnt      = 3'h0;
            n.addr_hi_done = 1'h0;
            n.data_seen    = 1'h0;
        end else if (!r.cs_d && !sel) begin
            n.phase = spi_mem_pkg::ph_idle;
            // only whole bytes count; a torn byte acts on nothing, though the phase still goes idle
            if (r.bit_cnt == 3'h0) begin
                case (r.opcode)
                    spi_mem_pkg::write_enable_cmd: begin
                        if (r.phase == spi_mem_pkg::ph_tail)
                            n.write_enable_latch = 1'h1;
                    end
                    spi_mem_pkg::write_disable_cmd: begin
                        if (r.phase == spi_mem_pkg::ph_tail)
                            n.write_enable_latch = 1'h0;
                    end
                    spi_mem_pkg::write_cmd: begin
                        if (r.phase == spi_mem_pkg::ph_data_in && r.data_seen) begin
                            n.write_commit = 1'h1;
                            n.write_enable_latch = 1'h0;
                        end
                    end
                    spi_mem_pkg::page_erase_cmd: begin
                        if (r.phase == spi_mem_pkg::ph_tail && r.write_enable_latch) begin
                            n.page_erase = 1'h1;
                            n.write_enable_latch = 1'h0;
                        end
                    end
                    spi_mem_pkg::chip_erase_cmd_a, spi_mem_pkg::chip_erase_cmd_b: begin
                        if (r.phase == spi_mem_pkg::ph_tail && r.write_enable_latch) begin
                            n.chip_erase = 1'h1;
                            n.write_enable_latch = 1'h0;
                        end
                    end
                    spi_mem_pkg::power_down_cmd: begin
                        if (r.phase == spi_mem_pkg::ph_tail) begin
                            n.asleep = 1'h1;
                            n.write_enable_latch = 1'h0;
                        end
                    end
                    spi_mem_pkg::resume_cmd: begin
                        if (r.phase == spi_mem_pkg::ph_tail)
                            n.asleep = 1'h0;
                    end
                    default: begin
                    end
                endcase
            end
        end else if (sel && !held && r.phase != spi_mem_pkg::ph_idle) begin
            // capture side
            if (sck_rise) begin
                n.shift_in = in_byte;
                n.bit_cnt  = r.bit_cnt + 3'h1;
                if (r.bit_cnt == 3'h7) begin
                    case (r.phase)
                        spi_mem_pkg::ph_opcode: begin
                            n.opcode = in_byte;
                            if (busy && in_byte != spi_mem_pkg::status_read_cmd)
                                n.phase = spi_mem_pkg::ph_ignore;
                            else if (r.asleep && in_byte != spi_mem_pkg::resume_cmd)
                                n.phase = spi_mem_pkg::ph_ignore;
                            else if (in_byte == spi_mem_pkg::write_cmd)
                                n.phase = r.write_enable_latch ? spi_mem_pkg::ph_addr
                                                : spi_mem_pkg::ph_ignore;
                            else if (spi_mem_pkg::addr_bytes(in_byte) != 2'h0)
                                n.phase = spi_mem_pkg::ph_addr;
                            else if (in_byte == spi_mem_pkg::status_read_cmd)
                                n.phase = spi_mem_pkg::ph_data_out;
                            else if (in_byte == spi_mem_pkg::write_enable_cmd ||
                                     in_byte == spi_mem_pkg::write_disable_cmd ||
                                     in_byte == spi_mem_pkg::chip_erase_cmd_a ||
                                     in_byte == spi_mem_pkg::chip_erase_cmd_b ||
                                     in_byte == spi_mem_pkg::power_down_cmd ||
                                     in_byte == spi_mem_pkg::resume_cmd)
                                n.phase = spi_mem_pkg::ph_tail;
                            else
                                n.phase = spi_mem_pkg::ph_ignore;
                        end
                        spi_mem_pkg::ph_addr: begin
                            if (!r.addr_hi_done) begin
                                n.addr[15:8]   = in_byte;
                                n.addr_hi_done = 1'h1;
                            end else begin
                                n.addr[7:0] = in_byte;
                                n.rd_addr   = addr_w'({r.addr[15:8], in_byte});
                                if (r.opcode == spi_mem_pkg::write_cmd)
                                    n.phase = spi_mem_pkg::ph_data_in;
                                else if (r.opcode == spi_mem_pkg::fast_read_cmd)
                                    n.phase = spi_mem_pkg::ph_dummy;
                                else if (r.opcode == spi_mem_pkg::read_cmd)
                                    n.phase = spi_mem_pkg::ph_data_out;
                                else
                                    n.phase = spi_mem_pkg::ph_tail;
                            end
                        end
                        spi_mem_pkg::ph_dummy: n.phase = spi_mem_pkg::ph_data_out;
                        spi_mem_pkg::ph_data_in: begin
                            // page buffer takes each byte; address wraps inside the page
                            n.wr_strobe = 1'h1;
                            n.wr_addr   = r.addr[addr_w-1:0];
                            n.wr_data   = in_byte;
                            n.data_seen = 1'h1;
                            n.addr[spi_mem_pkg::page_bits-1:0] =
                                r.addr[spi_mem_pkg::page_bits-1:0] + 5'h1;
                        end
                        spi_mem_pkg::ph_data_out: begin
                            n.addr    = r.addr + 16'h1;
                            n.rd_addr = r.addr[addr_w-1:0] + addr_w'(1);
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // launch side
            if (sck_fall && r.phase == spi_mem_pkg::ph_data_out) begin
                if (r.bit_cnt == 3'h0) begin
                    n.sout      = src[7];
                    n.shift_out = {src[6:0], 1'h0};
                end else begin
                    n.sout      = r.shift_out[7];
                    n.shift_out = {r.shift_out[6:0], 1'h0};
                end
            end
        end
        // drive only while returning data, selected and not paused
        n.sout_oe_n = !(n.phase == spi_mem_pkg::ph_data_out && !link.select_n
                        && sel && !held);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r           <= '0;
            r.cs_s      <= 2'h3;
            r.cs_d      <= 1'h1;
            r.hold_s    <= 2'h3;
            r.sout_oe_n <= 1'h1;
            r.standby   <= 1'h1;
        end else begin
            r <= n;
        end
    end

    assign link.serial_out      = r.sout;
    assign link.serial_out_oe_n = r.sout_oe_n;
    assign rd_addr              = r.rd_addr;
    assign wr_strobe            = r.wr_strobe;
    assign wr_addr              = r.wr_addr;
    assign wr_data              = r.wr_data;
    assign write_commit         = r.write_commit;
    assign page_erase           = r.page_erase;
    assign chip_erase           = r.chip_erase;
    assign power_down           = r.asleep;
    assign standby              = r.standby;
endmodule // spi_mem_device

//--- logic/spi_mem_master.sv
// module: master end that drives frames to the serial memory
`timescale 1ns/10ps
module spi_mem_master #(
    parameter int half_div = spi_mem_pkg::sck_half_cycles
) (
    input  wire logic        clk,
    input  wire logic        rst,
    spi_mem_if.master        link,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [15:0] address,
    input  wire logic [15:0] byte_count,
    input  wire logic        mode3,
    input  wire logic        pause,
    input  wire logic [7:0]  tx_data,
    output logic             tx_take,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    output logic             done,
    output logic             active
);
    typedef struct packed {
        spi_mem_pkg::master_state_type state;
        logic [7:0]  cnt;
        logic [2:0]  bit_cnt;
        logic [17:0] idx;
        logic [17:0] total;
        logic [17:0] hdr;
        logic [7:0]  shift;
        logic [7:0]  rx;
        logic [7:0]  op;
        logic [15:0] addr;
        logic [1:0]  miso_s;
        logic        last;
        logic        cs_n;
        logic        sck;
        logic        mosi;
        logic        hold_n;
        logic        tx_take;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic        done;
        logic        active;
    } mst_state_type;

    mst_state_type r;
    mst_state_type n;
    logic          tick;
    logic [17:0]   hdr_now;

    // byte sent at a frame position: opcode, address, dummy, then user data
    function automatic logic [7:0] frame_byte(input logic [17:0] i, input logic [7:0] op,
                                              input logic [15:0] a, input logic [17:0] h);
        if (i == 18'h0)
            return op;
        else if (i == 18'h1 && spi_mem_pkg::addr_bytes(op) != 2'h0)
            return a[15:8];
        else if (i == 18'h2 && spi_mem_pkg::addr_bytes(op) != 2'h0)
            return a[7:0];
        else if (i < h || spi_mem_pkg::returns_data(op))
            return 8'h00;
        return tx_data;
    endfunction

    assign tick    = (r.cnt == 8'(half_div - 1));
    assign hdr_now = 18'h1 + 18'(spi_mem_pkg::addr_bytes(opcode))
                   + 18'(spi_mem_pkg::dummy_byte(opcode));

    // frame sequencer, one half clock period per tick
    always_comb begin
        n = r;
        n.miso_s   = {r.miso_s[0], link.serial_out_line};
        n.tx_take  = 1'h0;
        n.rx_valid = 1'h0;
        n.done     = 1'h0;
        n.cnt      = tick ? 8'h0 : r.cnt + 8'h1;
        case (r.state)
            spi_mem_pkg::ms_idle: begin
                n.sck = mode3;
                n.cnt = 8'h0;
                if (start) begin
                    n.op      = opcode;
                    n.addr    = address;
                    n.hdr     = hdr_now;
                    n.total   = hdr_now + 18'(byte_count);
                    n.idx     = 18'h0;
                    n.bit_cnt = 3'h0;
                    n.last    = (byte_count == 16'h0 && hdr_now == 18'h1);
                    n.shift   = opcode;
                    n.mosi    = opcode[7];
                    n.cs_n    = 1'h0;
                    n.active  = 1'h1;
                    n.state   = spi_mem_pkg::ms_lead;
                end
            end
            spi_mem_pkg::ms_lead: begin
                n.sck = 1'h0;
                if (tick) begin
                    n.sck   = 1'h1;
                    n.state = spi_mem_pkg::ms_high;
                end
            end
            spi_mem_pkg::ms_high: begin
                if (tick) begin
                    n.rx      = {r.rx[6:0], r.miso_s[1]};
                    n.sck     = 1'h0;
                    n.bit_cnt = r.bit_cnt + 3'h1;
                    n.state   = spi_mem_pkg::ms_low;
                    n.mosi    = r.shift[6];
                    n.shift   = {r.shift[6:0], 1'h0};
                    if (r.bit_cnt == 3'h7) begin
                        n.idx = r.idx + 18'h1;
                        if (r.idx >= r.hdr && spi_mem_pkg::returns_data(r.op)) begin
                            n.rx_data  = {r.rx[6:0], r.miso_s[1]};
                            n.rx_valid = 1'h1;
                        end
                        n.last = (r.idx + 18'h1 == r.total);
                        if (r.idx + 18'h1 != r.total) begin
                            n.shift = frame_byte(r.idx + 18'h1, r.op, r.addr, r.hdr);
                            n.mosi  = n.shift[7];
                            n.tx_take = (r.idx + 18'h1 >= r.hdr) &&
                                        !spi_mem_pkg::returns_data(r.op);
                        end
                    end
                end
            end
            spi_mem_pkg::ms_low: begin
                // pause only while the clock is low, so no edge is cut short
                n.hold_n = !pause;
                if (pause) begin
                    n.cnt = r.cnt;
                end else if (tick && r.last && r.bit_cnt == 3'h0) begin
                    n.cs_n  = 1'h1;
                    n.state = spi_mem_pkg::ms_gap;
                end else if (tick) begin
                    n.sck   = 1'h1;
                    n.state = spi_mem_pkg::ms_high;
                end
            end
            default: begin
                if (r.cnt == 8'(spi_mem_pkg::cs_high_cycles + half_div)) begin
                    n.sck    = mode3;
                    n.done   = 1'h1;
                    n.active = 1'h0;
                    n.state  = spi_mem_pkg::ms_idle;
                end else begin
                    n.cnt = r.cnt + 8'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r        <= '0;
            r.cs_n   <= 1'h1;
            r.hold_n <= 1'h1;
        end else begin
            r <= n;
        end
    end

    assign link.select_n  = r.cs_n;
    assign link.sck       = r.sck;
    assign link.serial_in = r.mosi;
    assign link.pause_n   = r.hold_n;
    assign tx_take        = r.tx_take;
    assign rx_data        = r.rx_data;
    assign rx_valid       = r.rx_valid;
    assign done           = r.done;
    assign active         = r.active;
endmodule // spi_mem_master

//--- pkg/spi_mem_if.sv
// interface: serial memory link between master and device
`timescale 1ns/10ps
interface spi_mem_if;
    logic select_n;
    logic sck;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;
    logic pause_n;
    wire  serial_out_line;

    // released line shows the inverse, so a sample taken too early fails
    assign serial_out_line = serial_out_oe_n ? !serial_out : serial_out;

    modport device (input select_n, sck, serial_in, pause_n,
                    output serial_out, serial_out_oe_n);
    modport master (output select_n, sck, serial_in, pause_n,
                    input serial_out_line);
endinterface

//--- pkg/spi_mem_pkg.sv
// package: opcodes, status layout, frame table and timing of the serial memory link
package spi_mem_pkg;
    localparam logic [7:0] write_cmd         = 8'h02;
    localparam logic [7:0] read_cmd          = 8'h03;
    localparam logic [7:0] fast_read_cmd     = 8'h0b;
    localparam logic [7:0] write_disable_cmd = 8'h04;
    localparam logic [7:0] status_read_cmd   = 8'h05;
    localparam logic [7:0] write_enable_cmd  = 8'h06;
    localparam logic [7:0] page_erase_cmd    = 8'h42;
    localparam logic [7:0] chip_erase_cmd_a  = 8'h60;
    localparam logic [7:0] chip_erase_cmd_b  = 8'hc7;
    localparam logic [7:0] power_down_cmd    = 8'hb9;
    localparam logic [7:0] resume_cmd        = 8'hab;
    // status register layout, upper bits always zero
    localparam int busy_flag_pos   = 0;
    localparam int latch_pos       = 1;
    localparam logic [7:0] status_reset = 8'h00;
    // array geometry
    localparam int addr_width      = 13;
    localparam int page_bits       = 5;
    // timing at a 20 ns clock
    localparam int clk_period_ns   = 20;
    localparam int cs_high_ns      = 100;
    localparam int cs_high_cycles  = (cs_high_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int sck_half_cycles = 16;

    typedef enum logic [2:0] {
        ph_idle, ph_opcode, ph_addr, ph_dummy, ph_data_in, ph_data_out, ph_tail, ph_ignore
    } dev_phase_type;

    typedef enum logic [2:0] {ms_idle, ms_lead, ms_high, ms_low, ms_gap} master_state_type;

    // number of address bytes following an opcode
    function automatic logic [1:0] addr_bytes(input logic [7:0] op);
        return (op == write_cmd || op == read_cmd || op == fast_read_cmd ||
                op == page_erase_cmd) ? 2'h2 : 2'h0;
    endfunction

    function automatic logic dummy_byte(input logic [7:0] op);
        return op == fast_read_cmd;
    endfunction

    // commands whose data phase flows from device to master
    function automatic logic returns_data(input logic [7:0] op);
        return op == read_cmd || op == fast_read_cmd || op == status_read_cmd;
    endfunction
endpackage

//--- tb/spi_mem_assertions.sv
// checker: link assertions between the two ends
`timescale 1ns/10ps
module spi_mem_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic select_n,
    input wire logic sck,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic pause_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] bits;
    // rising sck edges in a frame; stays at 8 or more, low bits keep counting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) bits <= 8'h00;
        else if (select_n) bits <= 8'h00;
        else if (sck && !$past(sck)) bits <= (bits == 8'hff) ? 8'hf8 : bits + 8'h01;
    end
    a_deselect_floats: assert property (select_n [*6] |-> serial_out_oe_n)
        else $error("output driven while deselected");
    a_release_bound: assert property ($rose(select_n) |-> ##[1:5] serial_out_oe_n)
        else $error("output not released after deselect");
    a_pause_floats: assert property (!pause_n [*6] |-> serial_out_oe_n)
        else $error("output driven while paused");
    a_launch_on_fall: assert property (!serial_out_oe_n && $past(!serial_out_oe_n)
        && $changed(serial_out) |-> !$past(sck, 2)) else $error("output moved in clock high");
    a_input_held: assert property (!select_n && $past(!select_n) && sck && $past(sck)
        |-> $stable(serial_in)) else $error("input moved in clock high");
    a_whole_bytes: assert property ($rose(select_n) |-> bits[2:0] == 3'h0)
        else $error("frame ended mid byte");
    a_drive_after_header: assert property ($fell(serial_out_oe_n)
        |-> bits >= 8'h08 && !select_n && pause_n) else $error("output driven too early");
    a_lead_clock_idle: assert property ($fell(select_n) |=> !sck [*8])
        else $error("clock not low at frame start");
    c_data_return: cover property ($fell(serial_out_oe_n));
    c_paused: cover property (!select_n && $fell(pause_n));
    c_mode3_frame: cover property ($fell(select_n) && sck);
endmodule // spi_mem_assertions

//--- tb/testbench.sv
// testbench: both link ends joined, user sides driven and judged
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'h0, rst = 1'h1, start = 1'h0, mode3 = 1'h0, pause = 1'h0, busy = 1'h0;
    logic [7:0]  opcode = 8'h00, tx_data = 8'h3c, rd_data = 8'h00, rx_data, wr_data, rxq[$];
    logic [15:0] address = 16'h0000, byte_count = 16'h0000;
    logic        tx_take, rx_valid, done, active, wr_strobe, write_commit, page_erase;
    logic        chip_erase, power_down, standby;
    logic [12:0] rd_addr, wr_addr;
    int          err_total = 0, tests_run = 0, commits = 0, erases = 0;
    spi_mem_if link ();
    spi_mem_master spi_mem_master_i (.clk, .rst, .link, .start, .opcode, .address, .byte_count,
        .mode3, .pause, .tx_data, .tx_take, .rx_data, .rx_valid, .done, .active);
    spi_mem_device spi_mem_device_i (.clk, .rst, .link, .busy, .rd_data, .rd_addr, .wr_strobe,
        .wr_addr, .wr_data, .write_commit, .page_erase, .chip_erase, .power_down, .standby);
    spi_mem_assertions spi_mem_assertions_i (.clk, .rst, .select_n(link.select_n),
        .sck(link.sck), .serial_in(link.serial_in), .serial_out(link.serial_out),
        .serial_out_oe_n(link.serial_out_oe_n), .pause_n(link.pause_n));
    always #10 clk = ~clk;
    // array stand-in and pulse tallies
    always @(posedge clk) begin
        rd_data <= rd_addr[7:0] ^ 8'h5a;
        if (rx_valid === 1'h1) rxq.push_back(rx_data);
        if (write_commit === 1'h1) commits <= commits + 1;
        if ((page_erase | chip_erase) === 1'h1) erases <= erases + 1;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one frame, then a gap above the minimum
    task automatic run(input logic [7:0] op, input logic [15:0] a = 16'h0000,
                       input logic [15:0] n = 16'h0000);
        rxq.delete();
        {start, opcode, address, byte_count} <= {1'h1, op, a, n};
        @(posedge clk) start <= 1'h0;
        while (done !== 1'h1) @(negedge clk);
        repeat (8) @(posedge clk);
    endtask
    task automatic stat(input logic [7:0] exp);
        run(spi_mem_pkg::status_read_cmd, 16'h0000, 16'h0001);
        chk("status", {8'h00, exp}, {8'h00, rxq[0]});
    endtask
    // latch set and cleared; busy shown live and blocking other commands
    task automatic t_status;
        chk("standby", 16'h0001, {15'h0000, standby});
        stat(8'h00);
        run(spi_mem_pkg::write_enable_cmd);
        stat(8'h02);
        busy <= 1'h1;
        run(spi_mem_pkg::write_disable_cmd);
        stat(8'h03);
        busy <= 1'h0;
        run(spi_mem_pkg::write_disable_cmd);
        stat(8'h00);
    endtask
    // read over the top address, then mode 3 fast read paused mid data
    task automatic t_read;
        run(spi_mem_pkg::read_cmd, 16'h1fff, 16'h0002);
        chk("read count", 16'h0002, 16'(rxq.size()));
        chk("read top", 16'h00a5, {8'h00, rxq[0]});
        chk("read wrap", 16'h005a, {8'h00, rxq[1]});
        mode3 <= 1'h1;
        repeat (4) @(posedge clk);
        fork
            run(spi_mem_pkg::fast_read_cmd, 16'h0010, 16'h0001);
            begin
                repeat (1100) @(posedge clk);
                pause <= 1'h1;
                repeat (100) @(posedge clk);
                pause <= 1'h0;
            end
        join
        chk("fast read", 16'h004a, {8'h00, rxq[0]});
        chk("fast count", 16'h0001, 16'(rxq.size()));
    endtask
    // refused write, then two bytes wrapping in the page
    task automatic t_write;
        run(spi_mem_pkg::write_cmd, 16'h001f, 16'h0002);
        chk("refused", 16'h0000, 16'(commits));
        run(spi_mem_pkg::write_enable_cmd);
        run(spi_mem_pkg::write_cmd, 16'h001f, 16'h0002);
        chk("commits", 16'h0001, 16'(commits));
        chk("page wrap", 16'h0000, {3'h0, wr_addr});
        chk("write data", 16'h003c, {8'h00, wr_data});
        stat(8'h00);
    endtask
    // erases need the latch; power down holds until resume
    task automatic t_erase_pd;
        run(spi_mem_pkg::chip_erase_cmd_b);
        run(spi_mem_pkg::write_enable_cmd);
        run(spi_mem_pkg::page_erase_cmd, 16'h0040);
        run(spi_mem_pkg::write_enable_cmd);
        run(spi_mem_pkg::chip_erase_cmd_a);
        run(spi_mem_pkg::write_enable_cmd);
        run(spi_mem_pkg::chip_erase_cmd_b);
        chk("erases", 16'h0003, 16'(erases));
        run(spi_mem_pkg::write_enable_cmd);
        run(spi_mem_pkg::power_down_cmd);
        chk("power down", 16'h0001, {15'h0000, power_down});
        run(spi_mem_pkg::resume_cmd);
        chk("resumed", 16'h0000, {15'h0000, power_down});
        stat(8'h00);
    endtask
    // hang guard, far past the run length
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        t_status();
        t_read();
        t_write();
        t_erase_pd();
        final_report();
    end
endmodule // testbench
